// *** hw/csd_strap_decoder.sv ***
// Configuration strap decoder: latches and decodes board straps after reset.
// Assumes the analog front end presents sensed level codes and SPI ROM check result.
//
// Overview of operation
// - Pull-ups on data-out and clock select sideband slave
// - Pull-down on data-out selects UART
// - No pulls: try SPI master first
// - Never enable conflicting interface pairs together
// - Modes 1,2,3,6 route pins four, five sideband
// - Modes 4,5 block sideband slave and bridging
// - Bridging needs extra register configuration too
// - Shared pins carry SPI or strap/UART functions
// - Sample D+ and D- disable straps per port
// - Port disabled only when both straps high
// - USB2 disable also disables SuperSpeed side
// - Five-level fixed-port strap decode
// - Five-level charging strap decode
// - Six-level device mode strap decode
// - Capture straps at reset release, then hold
`timescale 1ns/1ps
`default_nettype none
module csd_strap_decoder
   import csd_pkg::*;
#(
   parameter int unsigned PORTS = NUM_PORTS
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Serial pin sense
   input  wire logic [1:0]       data_out_pull,
   input  wire logic [1:0]       clock_pull,
   // Multi-level strap codes
   input  wire logic [2:0]       fixed_port_strap,
   input  wire logic [2:0]       charging_ports_strap,
   input  wire logic [2:0]       dev_mode_strap,
   // Port disable straps
   input  wire logic [PORTS-1:0] port_dplus_disable_strap,
   input  wire logic [PORTS-1:0] port_dminus_disable_strap,
   // SPI ROM signature check
   input  wire logic             rom_check_done,
   input  wire logic             rom_sig_ok,
   // Bridge register configuration written
   input  wire logic             bridge_cfg_written,
   // Decoded outputs
   output logic                  straps_valid,
   output csd_cfg_t              cfg,
   output logic [PORTS-1:0]      usb2_port_dis,
   output logic [PORTS-1:0]      ss_port_dis
);
   // Decoder phases
   typedef enum logic [1:0] {ST_WAIT, ST_CAPTURE, ST_ROM, ST_HOLD} csd_state_t;

   // All state of the decoder
   typedef struct packed {
      csd_state_t       state;
      logic [1:0]       wait_cnt;   // Settling count for synchronisers
      logic [1:0]       do_pull;    // Latched data-out sense
      logic [1:0]       ck_pull;    // Latched clock sense
      logic [2:0]       nr_lvl;     // Latched fixed-port level
      logic [2:0]       bc_lvl;     // Latched charging level
      logic [2:0]       md_lvl;     // Latched mode level
      logic [PORTS-1:0] dp;         // Latched D+ disables
      logic [PORTS-1:0] dm;         // Latched D- disables
      logic             valid;
      csd_cfg_t         cfg;
      logic [PORTS-1:0] u2_dis;
      logic [PORTS-1:0] ss_dis;
   } csd_st_t;
   csd_st_t st_q, st_d;

   // Synchronised pin inputs
   localparam int unsigned SW = 4 + 9 + 2*PORTS;
   logic [SW-1:0] raw_pins;
   logic [SW-1:0] syn_pins;
   logic [1:0]       s_do, s_ck;
   logic [2:0]       s_nr, s_bc, s_md;
   logic [PORTS-1:0] s_dp, s_dm;

   assign raw_pins = {data_out_pull, clock_pull, fixed_port_strap, charging_ports_strap,
                      dev_mode_strap, port_dplus_disable_strap, port_dminus_disable_strap};

   // Pin synchroniser bank
   csd_sync #(
      .W (SW)
   ) u_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .pin_in  (raw_pins),
      .pin_out (syn_pins)
   );

   assign {s_do, s_ck, s_nr, s_bc, s_md, s_dp, s_dm} = syn_pins;

   // Thermometer decode of a five-level port count
   function automatic logic [3:0] lvl_ports(input logic [2:0] lvl);
      logic [3:0] r;
      r = PORTS_NONE;
      unique case (lvl)
         LVL_PD_200K: r = 4'h0;
         LVL_PU_200K: r = 4'h1;
         LVL_PD_10K:  r = 4'h3;
         LVL_PU_10K:  r = 4'h7;
         LVL_PD_10R:  r = 4'hf;
         default:     r = 4'h0;  // Illegal code: treat as lowest
      endcase
      return r;
   endfunction : lvl_ports

   // Next state
   always_comb
   begin
      st_d = st_q;
      unique case (st_q.state)
         // Let synchronisers settle after reset release
         ST_WAIT:
         begin
            st_d.wait_cnt = st_q.wait_cnt + 2'h1;
            if (st_q.wait_cnt == 2'(SYNC_STAGES))
               st_d.state = ST_CAPTURE;
         end
         // Latch all straps once
         ST_CAPTURE:
         begin
            st_d.do_pull = s_do;
            st_d.ck_pull = s_ck;
            st_d.nr_lvl  = s_nr;
            st_d.bc_lvl  = s_bc;
            st_d.md_lvl  = s_md;
            st_d.dp      = s_dp;
            st_d.dm      = s_dm;
            st_d.state   = ST_ROM;
         end
         // Decode; wait for ROM check when no pulls sensed
         ST_ROM:
         begin
            st_d.cfg.fixed_ports  = lvl_ports(st_q.nr_lvl);
            st_d.cfg.charge_ports = lvl_ports(st_q.bc_lvl);
            // Device mode 1..6 from level code
            unique case (st_q.md_lvl)
               LVL_PD_200K: st_d.cfg.dev_mode = 3'h1;
               LVL_PU_200K: st_d.cfg.dev_mode = 3'h2;
               LVL_PD_10K:  st_d.cfg.dev_mode = 3'h3;
               LVL_PU_10K:  st_d.cfg.dev_mode = 3'h4;
               LVL_PD_10R:  st_d.cfg.dev_mode = 3'h5;
               LVL_PU_10R:  st_d.cfg.dev_mode = 3'h6;
               default:     st_d.cfg.dev_mode = 3'h1;  // Illegal code
            endcase
            st_d.u2_dis = st_q.dp & st_q.dm;
            st_d.ss_dis = st_q.dp & st_q.dm;
            // Bundle copy of the port disables for downstream users
            st_d.cfg.port_dis = st_q.dp & st_q.dm;
            // Serial mode selection
            if (st_q.do_pull == PULL_UP && st_q.ck_pull == PULL_UP)
            begin
               st_d.cfg.ser_mode = CSD_SER_SMB;
               st_d.state        = ST_HOLD;
            end
            else if (st_q.do_pull == PULL_DOWN)
            begin
               st_d.cfg.ser_mode = CSD_SER_UART;
               st_d.state        = ST_HOLD;
            end
            else if (rom_check_done)
            begin
               // SPI first, else bridging fallback
               st_d.cfg.ser_mode = rom_sig_ok ? CSD_SER_SPI : CSD_SER_I2C;
               st_d.state        = ST_HOLD;
            end
            else
               st_d.cfg.ser_mode = CSD_SER_SPI;
         end
         // Settings frozen until next reset
         ST_HOLD:
         begin
            st_d.valid = 1'b1;
         end
      endcase
      // Derived enables from held settings
      st_d.cfg.prog45_sb = (st_d.cfg.dev_mode != 3'h4) && (st_d.cfg.dev_mode != 3'h5);
      st_d.cfg.spi_en  = st_d.cfg.ser_mode == CSD_SER_SPI;
      st_d.cfg.uart_en = st_d.cfg.ser_mode == CSD_SER_UART;
      st_d.cfg.smb_en  = (st_d.cfg.ser_mode == CSD_SER_SMB) && st_d.cfg.prog45_sb;
      st_d.cfg.i2c_en  = (st_d.cfg.ser_mode == CSD_SER_I2C) && st_d.cfg.prog45_sb
                         && bridge_cfg_written;
      // Shared pin function
      if (st_d.cfg.ser_mode == CSD_SER_SPI)
         st_d.cfg.pinfn = CSD_PIN_SPI;
      else if (st_d.cfg.ser_mode == CSD_SER_UART)
         st_d.cfg.pinfn = CSD_PIN_UART;
      else
         st_d.cfg.pinfn = CSD_PIN_STRAP;
   end

   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q                  <= '0;
         st_q.state            <= ST_WAIT;
         st_q.cfg.ser_mode     <= CSD_SER_SPI;
         st_q.cfg.dev_mode     <= 3'h1;
         st_q.cfg.pinfn        <= CSD_PIN_SPI;
      end
      else
         st_q <= st_d;
   end

   // Outputs straight from flops
   assign straps_valid  = st_q.valid;
   assign cfg           = st_q.cfg;
   assign usb2_port_dis = st_q.u2_dis;
   assign ss_port_dis   = st_q.ss_dis;

   // Assertions
   a_smb_select: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q.state == ST_ROM && st_q.do_pull == PULL_UP && st_q.ck_pull == PULL_UP)
      |=> cfg.ser_mode == CSD_SER_SMB) else $error("smb not selected");
   a_uart_select: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q.state == ST_ROM && st_q.do_pull == PULL_DOWN)
      |=> cfg.ser_mode == CSD_SER_UART) else $error("uart not selected");
   a_rom_fallback: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q.state == ST_ROM && st_q.do_pull == PULL_NONE && rom_check_done && !rom_sig_ok)
      |=> cfg.ser_mode == CSD_SER_I2C) else $error("no bridging fallback");
   a_no_conflict: assert property (@(posedge clk) disable iff (!rst_n)
      !(cfg.uart_en && (cfg.smb_en || cfg.spi_en)) && !(cfg.smb_en && cfg.i2c_en))
      else $error("conflicting interfaces");
   a_mode_block: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg.dev_mode == 3'h4 || cfg.dev_mode == 3'h5) |-> !cfg.smb_en && !cfg.i2c_en)
      else $error("sideband usable in mode 4/5");
   a_bridge_gate: assert property (@(posedge clk) disable iff (!rst_n)
      cfg.i2c_en |-> $past(bridge_cfg_written)) else $error("bridge without cfg");
   a_port_dis: assert property (@(posedge clk) disable iff (!rst_n)
      straps_valid |-> usb2_port_dis == (st_q.dp & st_q.dm) && ss_port_dis == usb2_port_dis
      && cfg.port_dis == usb2_port_dis)
      else $error("port disable mismatch");
   a_hold_stable: assert property (@(posedge clk) disable iff (!rst_n)
      straps_valid |=> $stable(cfg.ser_mode) && $stable(cfg.fixed_ports)
      && $stable(usb2_port_dis)) else $error("settings changed after latch");
   a_capture_time: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(st_q.state == ST_CAPTURE) |=> st_q.state == ST_ROM)
      else $error("capture not single cycle");
   c_smb: cover property (@(posedge clk) disable iff (!rst_n) cfg.smb_en);
   c_spi: cover property (@(posedge clk) disable iff (!rst_n) straps_valid && cfg.spi_en);
   c_i2c: cover property (@(posedge clk) disable iff (!rst_n) cfg.i2c_en);
   c_dis: cover property (@(posedge clk) disable iff (!rst_n) straps_valid && |usb2_port_dis);
endmodule : csd_strap_decoder
`default_nettype wire

// *** inc/csd_pkg.sv ***
// Constants and carrier types for the configuration strap decoder.
// Assumes a single core clock domain; level codes come from an analog sense front end.
package csd_pkg;
   // Port count and level code width
   localparam int unsigned NUM_PORTS = 4;
   localparam int unsigned LVL_W     = 3;
   // Sensed resistor level codes (shared by all multi-level straps)
   localparam logic [2:0] LVL_PD_200K = 3'h0;  // 200k pull-down
   localparam logic [2:0] LVL_PU_200K = 3'h1;  // 200k pull-up
   localparam logic [2:0] LVL_PD_10K  = 3'h2;  // 10k pull-down
   localparam logic [2:0] LVL_PU_10K  = 3'h3;  // 10k pull-up
   localparam logic [2:0] LVL_PD_10R  = 3'h4;  // 10 ohm pull-down
   localparam logic [2:0] LVL_PU_10R  = 3'h5;  // 10 ohm pull-up
   // Serial pin sense codes (data-out and clock pins)
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_UP   = 2'h1;
   localparam logic [1:0] PULL_DOWN = 2'h2;
   // Synchroniser depth for pin inputs
   localparam int unsigned SYNC_STAGES = 3;
   // Reset value of decoded vectors
   localparam logic [3:0] PORTS_NONE = 4'h0;
   // Shared serial pin modes
   typedef enum logic [1:0] {CSD_SER_SPI, CSD_SER_SMB, CSD_SER_I2C, CSD_SER_UART} csd_ser_t;
   // Shared serial pin functions
   typedef enum logic [1:0] {CSD_PIN_STRAP, CSD_PIN_SPI, CSD_PIN_UART} csd_pinfn_t;
   // Decoded settings bundle
   typedef struct packed {
      csd_ser_t   ser_mode;      // Serial pin mode
      logic [2:0] dev_mode;      // Device mode 1..6
      logic [3:0] port_dis;      // Port disabled (USB2 and SS)
      logic [3:0] fixed_ports;   // Non-removable ports
      logic [3:0] charge_ports;  // Charging ports
      logic       smb_en;        // Sideband slave usable
      logic       i2c_en;        // Bridge operational
      logic       uart_en;       // UART usable
      logic       spi_en;        // SPI master usable
      logic       prog45_sb;     // Prog pins 4,5 are sideband data/clock
      csd_pinfn_t pinfn;         // Shared pin function
   } csd_cfg_t;
endpackage : csd_pkg

// *** hw/csd_sync.sv ***
// Three-flop synchroniser with agreement filter for a bus of pin inputs.
// Assumes inputs are asynchronous to clk and held stable around reset release.
`timescale 1ns/1ps
`default_nettype none
module csd_sync
   import csd_pkg::*;
#(
   parameter int unsigned W = 1
)(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Pin side
   input  wire logic [W-1:0] pin_in,
   // Core side
   output logic      [W-1:0] pin_out
);
   // Synchroniser state
   typedef struct packed {
      logic [W-1:0] s1;   // First stage, read only by s2
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;  // Filtered value
   } csd_sync_st_t;
   csd_sync_st_t st_q, st_d;

   // Next state: change accepted when stages two and three agree
   always_comb
   begin
      st_d     = st_q;
      st_d.s1  = pin_in;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st_q.s2[i] == st_q.s3[i])
            st_d.val[i] = st_q.s3[i];
      end
   end

   // Register stage
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign pin_out = st_q.val;
endmodule : csd_sync
`default_nettype wire

// *** testbench/csd_board_model.sv ***
// Board side of the strap decoder: strap resistor levels and an SPI ROM check.
// Assumes the bench picks the resistor fit; the ROM check starts at reset release.
`timescale 1ns/1ps
`default_nettype none
module csd_board_model
   import csd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Chosen board fit
   input  wire logic [1:0] do_fit,
   input  wire logic [1:0] ck_fit,
   input  wire logic       sig_good,
   input  wire logic [3:0] rom_wait,
   // Sensed pull on the serial pins
   output logic      [1:0] data_out_pull,
   output logic      [1:0] clock_pull,
   // ROM signature check result
   output logic            rom_check_done,
   output logic            rom_sig_ok
);
   logic [3:0] cnt_q;  // Cycles since reset release, stops at rom_wait
   // Resistors are static levels
   assign data_out_pull = do_fit;
   assign clock_pull    = ck_fit;
   // ROM read takes rom_wait+1 cycles, then the result stands
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q          <= 4'h0;
         rom_check_done <= 1'b0;
      end
      else
      begin
         if (cnt_q != rom_wait) cnt_q <= cnt_q + 4'h1;
         rom_check_done <= (cnt_q == rom_wait);
      end
   end
   // Signature result valid only once done; toggling junk before
   assign rom_sig_ok = rom_check_done ? sig_good : cnt_q[0];
endmodule : csd_board_model
`default_nettype wire

// *** testbench/test_config_strap_decoder.sv ***
// Self-checking bench for the strap decoder with a board model beside it.
// Assumes the decoder settles within a few dozen cycles after reset release.
`timescale 1ns/1ps
`default_nettype none
module test_config_strap_decoder;
   import csd_pkg::*;
   logic       clk, rst_n, bridge, sgood;   // Clock, reset, bridge cfg, ROM sig
   logic [1:0] do_fit, ck_fit;              // Serial pin pulls
   logic [2:0] fix, chg, mode;              // Level codes
   logic [3:0] dp, dm, rwait;               // Port straps, ROM delay
   logic [1:0] dop, ckp;                    // Sensed pulls
   logic       rdone, rok;                  // ROM result
   logic       straps_valid;                // Decoder outputs
   csd_cfg_t   cfg;
   logic [3:0] usb2_port_dis, ss_port_dis;
   int         seed, bad_count, n_tests, t;
   csd_board_model board (.clk(clk), .rst_n(rst_n), .do_fit(do_fit), .ck_fit(ck_fit),
      .sig_good(sgood), .rom_wait(rwait), .data_out_pull(dop), .clock_pull(ckp),
      .rom_check_done(rdone), .rom_sig_ok(rok));
   csd_strap_decoder DUT (.clk(clk), .rst_n(rst_n), .data_out_pull(dop), .clock_pull(ckp),
      .fixed_port_strap(fix), .charging_ports_strap(chg), .dev_mode_strap(mode),
      .port_dplus_disable_strap(dp), .port_dminus_disable_strap(dm),
      .rom_check_done(rdone), .rom_sig_ok(rok), .bridge_cfg_written(bridge),
      .straps_valid(straps_valid), .cfg(cfg), .usb2_port_dis(usb2_port_dis),
      .ss_port_dis(ss_port_dis));
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Expected serial mode from fit kind and signature
   function automatic csd_ser_t exp_ser(input int k, input logic sg);
      return (k == 0) ? CSD_SER_SMB : (k == 1) ? CSD_SER_UART : sg ? CSD_SER_SPI : CSD_SER_I2C;
   endfunction : exp_ser
   // Compare one value
   task automatic check(input string nm, input logic [3:0] e, input logic [3:0] g);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   // Verdict and end of run
   task automatic report_and_stop;
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // One reset, capture and check with given board fit
   task automatic trial(input int k, input logic [2:0] f, c, m, input logic [3:0] p, q,
                        input logic sg, input logic [3:0] rw);
      int         i;
      csd_ser_t   es;
      logic       ok;
      logic [3:0] pd;
      @(posedge clk);
      do_fit <= (k == 0) ? PULL_UP : (k == 1) ? PULL_DOWN : PULL_NONE;
      ck_fit <= (k == 0) ? PULL_UP : PULL_NONE;
      {fix, chg, mode, dp, dm, sgood, rwait} <= {f, c, m, p, q, sg, rw};
      rst_n  <= 1'b0;
      bridge <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      i = 0;
      while (straps_valid !== 1'b1 && i < 60)
      begin
         @(posedge clk);
         #1;
         i++;
      end
      // Hung decoder: count it and move on to the next trial
      if (i >= 60)
      begin
         bad_count++;
         $display("[ERR] straps_valid expected 1 seen %b", straps_valid);
         return;
      end
      #1;
      es = exp_ser(k, sg);
      ok = (m != 3'h3) && (m != 3'h4);
      pd = p & q;
      check("ser_mode", 4'(es), 4'(cfg.ser_mode));
      check("dev_mode", 4'(m) + 4'h1, 4'(cfg.dev_mode));
      check("fixed_ports", (4'h1 << f) - 4'h1, cfg.fixed_ports);
      check("charge_ports", (4'h1 << c) - 4'h1, cfg.charge_ports);
      check("usb2_port_dis", pd, usb2_port_dis);
      check("ss_port_dis", pd, ss_port_dis);
      check("port_dis", pd, cfg.port_dis);
      check("smb_en", 4'(es == CSD_SER_SMB && ok), 4'(cfg.smb_en));
      check("uart_en", 4'(es == CSD_SER_UART), 4'(cfg.uart_en));
      check("spi_en", 4'(es == CSD_SER_SPI), 4'(cfg.spi_en));
      check("i2c_en_early", 4'h0, 4'(cfg.i2c_en));
      check("prog45_sb", 4'(ok), 4'(cfg.prog45_sb));
      check("pinfn", (es == CSD_SER_SPI) ? 4'(CSD_PIN_SPI) : (es == CSD_SER_UART) ?
            4'(CSD_PIN_UART) : 4'(CSD_PIN_STRAP), 4'(cfg.pinfn));
      check("conflict", 4'h0, {1'b0, cfg.uart_en & cfg.smb_en, cfg.uart_en & cfg.spi_en,
            cfg.smb_en & cfg.i2c_en});
      @(posedge clk);
      bridge <= 1'b1;
      {fix, chg, dp, dm} <= ~{f, c, p, q};
      do_fit <= PULL_DOWN;
      repeat (3) @(posedge clk);
      #1;
      check("i2c_en", 4'(es == CSD_SER_I2C && ok), 4'(cfg.i2c_en));
      check("ser_hold", 4'(es), 4'(cfg.ser_mode));
      check("dis_hold", pd, usb2_port_dis);
      check("fix_hold", (4'h1 << f) - 4'h1, cfg.fixed_ports);
   endtask : trial
   // Main sequence: corner fits then random fits
   initial
   begin
      {rst_n, bridge, sgood, do_fit, ck_fit, fix, chg, mode, dp, dm, rwait} = '0;
      seed = 32'h595c;
      bad_count = 0;
      n_tests = 0;
      repeat (20) @(posedge clk);
      trial(0, 3'h4, 3'h4, 3'h3, 4'hf, 4'hf, 1'b1, 4'h0);
      trial(2, 3'h0, 3'h0, 3'h4, 4'h5, 4'ha, 1'b0, 4'hf);
      trial(2, 3'h1, 3'h2, 3'h0, 4'h3, 4'h1, 1'b0, 4'h2);
      trial(2, 3'h3, 3'h1, 3'h1, 4'h0, 4'hf, 1'b1, 4'h9);
      trial(1, 3'h2, 3'h3, 3'h5, 4'h8, 4'h8, 1'b1, 4'h1);
      for (t = 0; t < 24; t++)
         trial($unsigned($random(seed)) % 3, 3'($unsigned($random(seed)) % 5),
               3'($unsigned($random(seed)) % 5), 3'($unsigned($random(seed)) % 6),
               4'($random(seed)), 4'($random(seed)), 1'($random(seed)),
               4'($random(seed)));
      report_and_stop();
   end
endmodule : test_config_strap_decoder
`default_nettype wire
